/* core/hpc_port.sv */
/*
  Host port control pins: strap capture, host strobe synchronising, request
  decode, ready and interrupt output drive with output-disable.
  Assumes host pins are asynchronous to ref_clk; the core answers each
  request with core_done and raises interrupts with core_int_req.
*/
`timescale 1ns/1ps
`default_nettype none
module hpc_port (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire hpc_pkg::hpc_host_t host_pins,
  input  wire logic             port_select_strap,
  input  wire logic             wide_mode_strap,
  input  wire logic             output_disable_n,
  input  wire logic             core_done,
  input  wire logic             core_int_req,
  input  wire logic             core_int_clr,
  output var  hpc_pkg::hpc_req_t  req,
  output logic                  port_selected,
  output logic                  wide_mode,
  output logic                  pullup_enable,
  output logic                  data_holder_set,
  output logic                  host_ready_out,
  output logic                  host_ready_oe_n,
  output logic                  host_interrupt_out,
  output logic                  host_interrupt_oe_n
);
  // ==========================================================
  // Strap capture: port select caught at reset release, wide mode followed every cycle
  logic rel_q, rel_d;
  logic sel_q, sel_d;
  logic wide_q, wide_d;

  always_comb begin
    rel_d = 1'b1;
    sel_d = sel_q;
    if (!rel_q) begin
      sel_d = port_select_strap;
    end
  end

  always_comb begin
    wide_d = wide_mode_strap;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rel_q  <= 1'b0;
      sel_q  <= hpc_pkg::STRAP_RST;
      wide_q <= hpc_pkg::STRAP_RST;
    end else begin
      rel_q  <= rel_d;
      sel_q  <= sel_d;
      wide_q <= wide_d;
    end
  end

  assign port_selected   = sel_q;
  assign wide_mode       = wide_q;
  assign pullup_enable   = !sel_q;
  assign data_holder_set = !sel_q;

  // ==========================================================
  // Host pin synchronisers
  localparam int unsigned W = $bits(hpc_pkg::hpc_host_t);
  logic [W-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [W-1:0] clean_q, clean_d;

  always_comb begin
    s1_d    = host_pins;
    s2_d    = s1_q;
    s3_d    = s2_q;
    clean_d = clean_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q    <= '1;
      s2_q    <= '1;
      s3_q    <= '1;
      clean_q <= '1;
    end else begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      s3_q    <= s3_d;
      clean_q <= clean_d;
    end
  end

  hpc_pkg::hpc_host_t h;
  assign h = hpc_pkg::hpc_host_t'(clean_q);

  // ==========================================================
  // Access sequencing
  hpc_pkg::hpc_state_t st_q, st_d;
  hpc_pkg::hpc_req_t   req_d;
  logic                as_prev_q, as_prev_d;
  logic                rdy_q, rdy_d;
  logic                active;

  // Access only while chip select low
  assign active = sel_q && !h.chip_select_n && !h.data_strobe_n;

  always_comb begin
    st_d      = st_q;
    req_d     = '0;
    rdy_d     = rdy_q;
    as_prev_d = h.addr_strobe_n;
    req_d.addr_latch = sel_q && as_prev_q && !h.addr_strobe_n;
    unique case (st_q)
      hpc_pkg::HPC_IDLE: begin
        rdy_d = 1'b1;
        if (active) begin
          req_d.valid          = 1'b1;
          req_d.read_not_write = h.read_not_write;
          req_d.reg_sel        = wide_q ? hpc_pkg::SEL_DATA
                                 : {h.register_select_hi, h.register_select_lo};
          req_d.byte_half      = wide_q ? 1'b0 : h.byte_half_flag;
          rdy_d                = 1'b0;
          st_d                 = hpc_pkg::HPC_ACCESS;
        end
      end
      hpc_pkg::HPC_ACCESS: begin
        if (core_done) begin
          rdy_d = 1'b1;
          st_d  = hpc_pkg::HPC_WAIT;
        end
      end
      hpc_pkg::HPC_WAIT: begin
        // Waits for strobe release so one strobe yields one request
        if (h.data_strobe_n || h.chip_select_n) begin
          st_d = hpc_pkg::HPC_IDLE;
        end
      end
      default: begin
        st_d = hpc_pkg::HPC_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Interrupt flag
  logic int_q, int_d;

  // Active-low interrupt, set wins over clear
  always_comb begin
    int_d = int_q;
    if (core_int_clr) begin
      int_d = 1'b0;
    end
    if (core_int_req && !wide_q) begin
      int_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= hpc_pkg::HPC_IDLE;
      req       <= '0;
      rdy_q     <= hpc_pkg::RDY_RST;
      as_prev_q <= 1'b1;
      int_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      req       <= req_d;
      rdy_q     <= rdy_d;
      as_prev_q <= as_prev_d;
      int_q     <= int_d;
    end
  end

  // ==========================================================
  // Pin drive
  // Ready high in reset
  assign host_ready_out      = !resetn ? hpc_pkg::RDY_RST : rdy_q;
  // Interrupt high in reset; idle high in wide mode
  assign host_interrupt_out  = (!resetn || wide_q) ? hpc_pkg::INT_RST : !int_q;
  assign host_ready_oe_n     = !output_disable_n;
  assign host_interrupt_oe_n = !output_disable_n || wide_q;

  // ==========================================================
  // Checks
  ready_in_reset_a: assert property (
    @(posedge ref_clk) !resetn |-> host_ready_out)
    else $error("ready low during reset");
  off_float_a: assert property (
    @(posedge ref_clk) !output_disable_n |-> host_ready_oe_n && host_interrupt_oe_n)
    else $error("outputs driven while disabled");
  wide_int_idle_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) wide_q |-> host_interrupt_out)
    else $error("interrupt used in wide mode");
  strap_hold_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) rel_q |=> $stable(sel_q))
    else $error("strap changed after release");
  strap_catch_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) !rel_q |=> sel_q == $past(port_select_strap))
    else $error("strap not caught at release");
  deselect_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) !sel_q |-> pullup_enable && !req.valid)
    else $error("deselected port active");
  busy_ready_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) req.valid |-> !host_ready_out)
    else $error("ready high with new request");
  int_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) core_int_req && !wide_q |=> !host_interrupt_out)
    else $error("interrupt not raised");
  wide_sel_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) req.valid && wide_q |-> req.reg_sel == hpc_pkg::SEL_DATA)
    else $error("select used in wide mode");
endmodule
`default_nettype wire

/* core/hpc_pkg.sv */
/*
  Constants and carrier types for the host port control pins block.
  Assumes one 40 MHz clock domain and an active-low asynchronous reset.
*/
package hpc_pkg;
  // ==========================================================
  // Constants
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic        STRAP_RST   = 1'b0;
  localparam logic        RDY_RST     = 1'b1;
  localparam logic        INT_RST     = 1'b1;
  localparam logic [1:0]  SEL_ADDR    = 2'h1;
  localparam logic [1:0]  SEL_DATA_AI = 2'h2;
  localparam logic [1:0]  SEL_DATA    = 2'h3;
  localparam logic [1:0]  SEL_CTRL    = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    HPC_IDLE   = 2'b00,
    HPC_ACCESS = 2'b01,
    HPC_WAIT   = 2'b11
  } hpc_state_t;

  typedef struct packed {
    logic       chip_select_n;
    logic       data_strobe_n;
    logic       addr_strobe_n;
    logic       read_not_write;
    logic       register_select_hi;
    logic       register_select_lo;
    logic       byte_half_flag;
  } hpc_host_t;

  typedef struct packed {
    logic       valid;
    logic       read_not_write;
    logic [1:0] reg_sel;
    logic       byte_half;
    logic       addr_latch;
  } hpc_req_t;
endpackage

/* test/hpc_host.sv */
/*
  Host processor model driving the host port pins.
  Assumes the bench calls access and latch_addr by hierarchy.
*/
`timescale 1ns/1ps
`default_nettype none
module hpc_host (
  input  wire logic               ref_clk,
  input  wire logic               host_ready_out,
  output var  hpc_pkg::hpc_host_t host_pins
);
  // Released lines sit high, as the pin pullups would leave them
  initial host_pins = '1;
  task automatic latch_addr();
    @(negedge ref_clk) host_pins.addr_strobe_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    host_pins.addr_strobe_n = 1'b1;
  endtask
  task automatic access(input logic rnw, input logic [1:0] sel, input logic half, output logic ok);
    int n;
    @(negedge ref_clk);
    host_pins = '{1'b0, 1'b0, 1'b1, rnw, sel[1], sel[0], half};
    n = 0;
    while (host_ready_out !== 1'b0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    ok = (n < 20);
    while (host_ready_out !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    host_pins = '1;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* test/host_port_control_pins_bench.sv */
/*
  Self-checking bench for the host port control pins.
  Assumes hpc_host as the host and an instant core answer.
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_control_pins_bench;
  logic ref_clk = 1'b0, resetn = 1'b0, strap = 1'b0, wide = 1'b0, odn = 1'b1;
  logic core_done = 1'b0, int_req = 1'b0, int_clr = 1'b0, ok;
  hpc_pkg::hpc_host_t pins;
  hpc_pkg::hpc_req_t  req, last_req;
  logic sel_q, wide_q, pu, hold, rdy, rdy_oe_n, irq, irq_oe_n;
  int fails = 0, cmp_count = 0, n_valid = 0, n_latch = 0, cycles = 0, nv;
  always #12.5 ref_clk = ~ref_clk;
  hpc_port i_hpc_port (.ref_clk(ref_clk), .resetn(resetn), .host_pins(pins), .port_select_strap(strap),
    .wide_mode_strap(wide), .output_disable_n(odn), .core_done(core_done), .core_int_req(int_req),
    .core_int_clr(int_clr), .req(req), .port_selected(sel_q), .wide_mode(wide_q), .pullup_enable(pu),
    .data_holder_set(hold), .host_ready_out(rdy), .host_ready_oe_n(rdy_oe_n),
    .host_interrupt_out(irq), .host_interrupt_oe_n(irq_oe_n));
  hpc_host i_hpc_host (.ref_clk(ref_clk), .host_ready_out(rdy), .host_pins(pins));
  // ==========================================================
  // Core stand-in answers every request at once
  // Pulses are counted mid-cycle, away from the edge that moves them
  always @(negedge ref_clk) begin
    cycles++;
    if (req.valid === 1'b1) begin
      last_req = req;
      n_valid++;
    end
    if (req.addr_latch === 1'b1) n_latch++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end
  always @(negedge ref_clk) core_done <= req.valid;
  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic strap_level);
    @(negedge ref_clk) resetn = 1'b0;
    strap = strap_level;
    repeat (10) @(negedge ref_clk);
    check({5'h00, rdy, irq, sel_q}, 8'h06);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    do_reset(1'b0);
    check({5'h00, sel_q, pu, hold}, 8'h03);
    nv = n_valid;
    i_hpc_host.access(1'b0, 2'h3, 1'b0, ok);
    check({7'h00, ok}, 8'h00);
    check(8'(n_valid - nv), 8'h00);
    // Strap only moves inside reset, so the port stays deselected here
    repeat (3) @(negedge ref_clk);
    check({7'h00, sel_q}, 8'h00);
    do_reset(1'b1);
    check({5'h00, sel_q, pu, hold}, 8'h04);
    nv = n_valid;
    for (int i = 0; i < 8; i++) begin
      i_hpc_host.access(i[2], i[1:0], ^i[2:0], ok);
      check({6'h00, ok, rdy}, 8'h03);
      check({4'h0, last_req.read_not_write, last_req.reg_sel, last_req.byte_half}, {4'h0, i[2:0], ^i[2:0]});
    end
    check(8'(n_valid - nv), 8'h08);
    nv = n_latch;
    i_hpc_host.latch_addr();
    check(8'(n_latch - nv), 8'h01);
    int_req = 1'b1;
    int_clr = 1'b1;
    @(negedge ref_clk) int_clr = 1'b0;
    int_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({6'h00, irq, irq_oe_n}, 8'h00);
    int_clr = 1'b1;
    @(negedge ref_clk) int_clr = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({6'h00, irq, irq_oe_n}, 8'h02);
    odn = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({6'h00, rdy_oe_n, irq_oe_n}, 8'h03);
    odn = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({6'h00, rdy_oe_n, irq_oe_n}, 8'h00);
    wide = 1'b1;
    repeat (3) @(negedge ref_clk);
    check({5'h00, wide_q, irq, irq_oe_n}, 8'h07);
    // Selects and half marker differ from the forced values, so an access that escapes the wide-mode forcing shows
    nv = n_valid;
    i_hpc_host.access(1'b1, 2'h0, 1'b1, ok);
    check({6'h00, ok, rdy}, 8'h03);
    check(8'(n_valid - nv), 8'h01);
    check({5'h00, last_req.reg_sel, last_req.byte_half}, {5'h00, hpc_pkg::SEL_DATA, 1'b0});
    wide = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({7'h00, wide_q}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
